// ===== rtl/wscr_regs.sv
// Wake source configuration register bank of the system basis device.
// Assumes reg_wr/reg_rd are one-cycle strobes from the SPI decoder on core_clk.
// Operation
// RULE1: Second cyclic timer wakes only while internal bit 7 is 1.
// RULE2: First cyclic timer wakes only while internal bit 6 is 1.
// RULE3: Reserved bits always read as 0.
// RULE4: Internal bit 2 is the high bit of the stop watchdog off code, writable by host and device.
// RULE5: Global bit 0 lets only wake events raise the interrupt, 1 lets all status bits raise it.
// RULE6: Measure select 1 enables measurement in normal mode and ignores inputs 1 and 2 enables.
// RULE7: External bits 2, 1, 0 enable wake inputs 3, 2, 1.
// RULE8: Power-on or soft reset loads the external register with 0x07.
// RULE9: Power-on or soft reset loads internal and pull registers with 0x00.
// RULE10: Restart clears external bits 6, 4 and 3 and keeps the rest.
// RULE11: Fail-safe entry forces the external register to x0x0 0111.
// RULE12: A transceiver whose mode field is wake capable acts as a wake source.
// RULE13: Each pull field decodes 00 none, 01 down, 10 up, 11 automatic.
// RULE14: Host ignores inputs 1 and 2 level bits while measurement is selected.
// RULE15: The low bit of the stop watchdog off code sits in watchdog control bit 6.
// RULE16: Host writes to reserved bits are ignored.
`timescale 1ns/100ps
module wscr_regs (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic soft_reset,
   input wire logic restart,
   input wire logic failsafe_entry,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic wd_off_high_set,
   input wire logic wd_off_high_clr,
   input wire logic [7:0] watchdog_control,
   input wire logic [1:0] can_mode,
   input wire logic [1:0] lin1_mode,
   input wire logic [1:0] lin2_mode,
   input wire logic normal_mode,
   input wire logic wake_event,
   input wire logic status_event,
   output logic int_request,
   output wscr_pkg::wscr_wake_src_t wake_sources,
   output logic measure_enable,
   output logic [1:0] stop_watchdog_off_code,
   output wscr_pkg::wscr_pull_ctl_t pull_ctl
);
   // ==========================================================
   // Registers
   logic [7:0] internal_wake_control_r, internal_wake_control_nxt;
   logic [7:0] external_wake_control_r, external_wake_control_nxt;
   logic [7:0] wake_input_pull_control_r, wake_input_pull_control_nxt;
   logic [7:0] reg_rdata_nxt;
   logic reg_hit_nxt;

   function automatic logic [7:0] merge_write(input logic [7:0] old, input logic [7:0] wd,
                                              input logic [7:0] mask);
      merge_write = (old & ~mask) | (wd & mask);
   endfunction : merge_write

   function automatic logic [2:0] pull_decode(input logic [1:0] fld);
      wscr_pkg::wscr_pull_t p;
      p = wscr_pkg::wscr_pull_t'(fld);
      case (p)
         wscr_pkg::WSCR_PULL_DOWN: pull_decode = 3'b100;
         wscr_pkg::WSCR_PULL_UP: pull_decode = 3'b010;
         wscr_pkg::WSCR_PULL_AUTO: pull_decode = 3'b001;
         default: pull_decode = 3'b000;
      endcase
   endfunction : pull_decode

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [7:0] iw;
      iw = internal_wake_control_r;
      internal_wake_control_nxt = internal_wake_control_r;
      external_wake_control_nxt = external_wake_control_r;
      wake_input_pull_control_nxt = wake_input_pull_control_r;
      if (soft_reset) begin
         internal_wake_control_nxt = wscr_pkg::INT_WAKE_RESET; // RULE9
         external_wake_control_nxt = wscr_pkg::EXT_WAKE_RESET; // RULE8
         wake_input_pull_control_nxt = wscr_pkg::PULL_RESET; // RULE9
      end else if (failsafe_entry) begin
         // Fail-safe wins over a host write so the device can always be woken again
         external_wake_control_nxt = (external_wake_control_r & wscr_pkg::EXT_FAILSAFE_KEEP)
                                     | wscr_pkg::EXT_FAILSAFE_SET; // RULE11
      end else if (restart) begin
         external_wake_control_nxt = external_wake_control_r & wscr_pkg::EXT_RESTART_KEEP; // RULE10
      end else begin
         if (reg_wr && reg_addr == wscr_pkg::ADDR_INT_WAKE) begin
            iw = merge_write(iw, reg_wdata, wscr_pkg::INT_WAKE_MASK); // RULE16
         end
         if (reg_wr && reg_addr == wscr_pkg::ADDR_EXT_WAKE) begin
            external_wake_control_nxt = merge_write(external_wake_control_r, reg_wdata,
                                                    wscr_pkg::EXT_WAKE_MASK); // RULE16
         end
         if (reg_wr && reg_addr == wscr_pkg::ADDR_PULL) begin
            wake_input_pull_control_nxt = merge_write(wake_input_pull_control_r, reg_wdata,
                                                      wscr_pkg::PULL_MASK); // RULE16
         end
         // Device update of the watchdog code bit beats a same-cycle host write
         if (wd_off_high_set) begin
            iw[wscr_pkg::INT_WDH_BIT] = 1'b1; // RULE4
         end else if (wd_off_high_clr) begin
            iw[wscr_pkg::INT_WDH_BIT] = 1'b0; // RULE4
         end
         internal_wake_control_nxt = iw;
      end
   end

   // Read path: registered data, unmapped addresses read zero
   always_comb begin
      reg_rdata_nxt = 8'h00;
      reg_hit_nxt = 1'b0;
      if (reg_rd) begin
         case (reg_addr)
            wscr_pkg::ADDR_INT_WAKE: begin
               reg_rdata_nxt = internal_wake_control_r & wscr_pkg::INT_WAKE_MASK; // RULE3
               reg_hit_nxt = 1'b1;
            end
            wscr_pkg::ADDR_EXT_WAKE: begin
               reg_rdata_nxt = external_wake_control_r & wscr_pkg::EXT_WAKE_MASK; // RULE3
               reg_hit_nxt = 1'b1;
            end
            wscr_pkg::ADDR_PULL: begin
               reg_rdata_nxt = wake_input_pull_control_r & wscr_pkg::PULL_MASK; // RULE3
               reg_hit_nxt = 1'b1;
            end
            default: begin
               reg_rdata_nxt = 8'h00;
               reg_hit_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         internal_wake_control_r <= wscr_pkg::INT_WAKE_RESET; // RULE9
         external_wake_control_r <= wscr_pkg::EXT_WAKE_RESET; // RULE8
         wake_input_pull_control_r <= wscr_pkg::PULL_RESET; // RULE9
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         internal_wake_control_r <= internal_wake_control_nxt;
         external_wake_control_r <= external_wake_control_nxt;
         wake_input_pull_control_r <= wake_input_pull_control_nxt;
         reg_rdata <= reg_rdata_nxt;
         reg_hit <= reg_hit_nxt;
      end
   end

   // ==========================================================
   // Decoded controls
   logic meas_sel;
   logic [2:0] p1, p2, p3;
   assign meas_sel = external_wake_control_r[wscr_pkg::EXT_MEAS_BIT];
   assign wake_sources.timer2 = internal_wake_control_r[wscr_pkg::INT_T2_BIT]; // RULE1
   assign wake_sources.timer1 = internal_wake_control_r[wscr_pkg::INT_T1_BIT]; // RULE2
   assign wake_sources.hv3 = external_wake_control_r[wscr_pkg::EXT_WK3_BIT]; // RULE7
   // Measurement takes inputs 1 and 2 away from wake; their level bits are then meaningless
   assign wake_sources.hv2 = external_wake_control_r[wscr_pkg::EXT_WK2_BIT] & ~meas_sel; // RULE6 RULE7
   assign wake_sources.hv1 = external_wake_control_r[wscr_pkg::EXT_WK1_BIT] & ~meas_sel; // RULE6 RULE7
   assign wake_sources.can = (can_mode == wscr_pkg::BUS_MODE_WAKE); // RULE12
   assign wake_sources.lin1 = (lin1_mode == wscr_pkg::BUS_MODE_WAKE); // RULE12
   assign wake_sources.lin2 = (lin2_mode == wscr_pkg::BUS_MODE_WAKE); // RULE12
   assign measure_enable = meas_sel & normal_mode; // RULE6
   assign stop_watchdog_off_code = {internal_wake_control_r[wscr_pkg::INT_WDH_BIT],
                                    watchdog_control[wscr_pkg::WDCTL_LOW_BIT]}; // RULE4 RULE15
   // Combinational from the registered global bit; status inputs are same-domain
   assign int_request = wake_event
                        | (external_wake_control_r[wscr_pkg::EXT_GLOBAL_BIT] & status_event); // RULE5
   assign p1 = pull_decode(wake_input_pull_control_r[1:0]); // RULE13
   assign p2 = pull_decode(wake_input_pull_control_r[3:2]); // RULE13
   assign p3 = pull_decode(wake_input_pull_control_r[5:4]); // RULE13
   assign pull_ctl = {p3[2], p3[1], p2[2], p2[1], p1[2], p1[1], p3[0], p2[0], p1[0]};

   // ==========================================================
   // Assertions: wake sources and measure enable
   // Host write that no reset, restart or fail-safe overrides in the same cycle
   logic wr_taken;
   assign wr_taken = reg_wr & ~soft_reset & ~failsafe_entry & ~restart;
   AST_T2_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
      wr_taken && reg_addr == wscr_pkg::ADDR_INT_WAKE |=>
      wake_sources.timer2 == $past(reg_wdata[wscr_pkg::INT_T2_BIT]))
      else $error("timer2 enable lost");
   AST_T2_OFF: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
      !internal_wake_control_r[wscr_pkg::INT_T2_BIT] |-> !wake_sources.timer2)
      else $error("timer2 wakes while off");
   AST_T1_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
      wr_taken && reg_addr == wscr_pkg::ADDR_INT_WAKE |=>
      wake_sources.timer1 == $past(reg_wdata[wscr_pkg::INT_T1_BIT]))
      else $error("timer1 enable lost");
   AST_T1_OFF: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
      !internal_wake_control_r[wscr_pkg::INT_T1_BIT] |-> !wake_sources.timer1)
      else $error("timer1 wakes while off");
   AST_HV3_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
      wr_taken && reg_addr == wscr_pkg::ADDR_EXT_WAKE |=>
      wake_sources.hv3 == $past(reg_wdata[wscr_pkg::EXT_WK3_BIT]))
      else $error("input 3 enable lost");
   AST_HV12_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
      wr_taken && reg_addr == wscr_pkg::ADDR_EXT_WAKE && !reg_wdata[wscr_pkg::EXT_MEAS_BIT] |=>
      wake_sources.hv2 == $past(reg_wdata[wscr_pkg::EXT_WK2_BIT])
      && wake_sources.hv1 == $past(reg_wdata[wscr_pkg::EXT_WK1_BIT]))
      else $error("input 1/2 enable lost");
   AST_MEAS_MASK: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
      meas_sel |-> !wake_sources.hv1 && !wake_sources.hv2)
      else $error("wake 1/2 active under measure");
   AST_MEAS_ON: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
      measure_enable == (meas_sel && normal_mode))
      else $error("measure enable wrong");
   AST_BUS_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE12
      wake_sources.can == (can_mode == 2'h1) && wake_sources.lin1 == (lin1_mode == 2'h1)
      && wake_sources.lin2 == (lin2_mode == 2'h1))
      else $error("bus wake source wrong");

   // ==========================================================
   // Assertions: interrupt scope and stop watchdog code
   AST_INT_SCOPE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
      !external_wake_control_r[wscr_pkg::EXT_GLOBAL_BIT] && !wake_event |-> !int_request)
      else $error("interrupt outside scope");
   AST_INT_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
      wake_event |-> int_request)
      else $error("wake event without interrupt");
   AST_INT_GLOBAL: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
      external_wake_control_r[wscr_pkg::EXT_GLOBAL_BIT] && status_event |-> int_request)
      else $error("status event without interrupt");
   AST_WD_SET: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
      wd_off_high_set && !soft_reset && !failsafe_entry && !restart |=> stop_watchdog_off_code[1])
      else $error("watchdog code bit not set");
   AST_WD_CLR: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
      wd_off_high_clr && !wd_off_high_set && !soft_reset && !failsafe_entry && !restart |=>
      !stop_watchdog_off_code[1])
      else $error("watchdog code bit not cleared");
   AST_WD_HOST: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
      wr_taken && reg_addr == wscr_pkg::ADDR_INT_WAKE && !wd_off_high_set && !wd_off_high_clr |=>
      stop_watchdog_off_code[1] == $past(reg_wdata[wscr_pkg::INT_WDH_BIT]))
      else $error("watchdog code write lost");
   AST_WD_LOW: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE15
      stop_watchdog_off_code[0] == watchdog_control[wscr_pkg::WDCTL_LOW_BIT])
      else $error("watchdog code low bit wrong");

   // ==========================================================
   // Assertions: soft reset, restart and fail-safe
   AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8 RULE9
      soft_reset |=> external_wake_control_r == wscr_pkg::EXT_WAKE_RESET
      && internal_wake_control_r == wscr_pkg::INT_WAKE_RESET && wake_input_pull_control_r == wscr_pkg::PULL_RESET)
      else $error("soft reset values wrong");
   AST_RESTART: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
      restart && !soft_reset && !failsafe_entry |=>
      external_wake_control_r == ($past(external_wake_control_r) & wscr_pkg::EXT_RESTART_KEEP))
      else $error("restart wrong");
   AST_FAILSAFE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
      failsafe_entry && !soft_reset |=>
      external_wake_control_r[6:0] == {1'b0, $past(external_wake_control_r[5]), 5'b00111})
      else $error("fail-safe value wrong");
   AST_FAILSAFE_TOP: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
      failsafe_entry && !soft_reset |=> external_wake_control_r[7] == $past(external_wake_control_r[7]))
      else $error("fail-safe lost global bit");
   AST_FAILSAFE_WAKE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
      failsafe_entry && !soft_reset |=> wake_sources.hv3)
      else $error("fail-safe left input 3 off");

   // ==========================================================
   // Assertions: read path, reserved bits and pull decode
   AST_RSVD_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
      reg_rd && reg_addr == wscr_pkg::ADDR_EXT_WAKE |=> reg_rdata[6] == 1'b0 && reg_rdata[4:3] == 2'h0)
      else $error("reserved bit read nonzero");
   AST_RSVD_READ_INT: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
      reg_rd && reg_addr == wscr_pkg::ADDR_INT_WAKE |=>
      reg_rdata[5:3] == 3'h0 && reg_rdata[1:0] == 2'h0)
      else $error("reserved internal bit read nonzero");
   AST_RSVD_READ_PULL: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
      reg_rd && reg_addr == wscr_pkg::ADDR_PULL |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved pull bit read nonzero");
   AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
      reg_rd && reg_addr != wscr_pkg::ADDR_INT_WAKE && reg_addr != wscr_pkg::ADDR_EXT_WAKE
      && reg_addr != wscr_pkg::ADDR_PULL |=> reg_rdata == 8'h00 && !reg_hit)
      else $error("unmapped read not zero");
   AST_RSVD_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE16
      (wake_input_pull_control_r[7:6] == 2'b00)[*2])
      else $error("reserved pull bits stored");
   AST_RSVD_STORE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE16
      internal_wake_control_r[5:3] == 3'h0 && internal_wake_control_r[1:0] == 2'h0
      && external_wake_control_r[6] == 1'b0 && external_wake_control_r[4:3] == 2'h0)
      else $error("reserved bits stored");
   AST_PULL_ONEHOT: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
      $onehot0({pull_ctl.pd1, pull_ctl.pu1, pull_ctl.auto1}) && $onehot0({pull_ctl.pd2, pull_ctl.pu2, pull_ctl.auto2})
      && $onehot0({pull_ctl.pd3, pull_ctl.pu3, pull_ctl.auto3}))
      else $error("pull controls clash");
   AST_PULL_DECODE1: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
      pull_ctl.pd1 == (wake_input_pull_control_r[1:0] == 2'h1)
      && pull_ctl.pu1 == (wake_input_pull_control_r[1:0] == 2'h2)
      && pull_ctl.auto1 == (wake_input_pull_control_r[1:0] == 2'h3))
      else $error("pull field 1 decode wrong");
   AST_PULL_DECODE2: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
      pull_ctl.pd2 == (wake_input_pull_control_r[3:2] == 2'h1)
      && pull_ctl.pu2 == (wake_input_pull_control_r[3:2] == 2'h2)
      && pull_ctl.auto2 == (wake_input_pull_control_r[3:2] == 2'h3))
      else $error("pull field 2 decode wrong");
   AST_PULL_DECODE3: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
      pull_ctl.pd3 == (wake_input_pull_control_r[5:4] == 2'h1)
      && pull_ctl.pu3 == (wake_input_pull_control_r[5:4] == 2'h2)
      && pull_ctl.auto3 == (wake_input_pull_control_r[5:4] == 2'h3))
      else $error("pull field 3 decode wrong");

   // ==========================================================
   // Covers of the main scenarios
   COV_MEAS: cover property (@(posedge core_clk) disable iff (!rst_b) measure_enable);
   COV_FAILSAFE: cover property (@(posedge core_clk) disable iff (!rst_b) failsafe_entry ##2 reg_rd);
   COV_GLOBAL_INT: cover property (@(posedge core_clk) disable iff (!rst_b)
      int_request && !wake_event);
   COV_WD_BOTH: cover property (@(posedge core_clk) disable iff (!rst_b) wd_off_high_set && wd_off_high_clr);
   COV_FAILSAFE_WRITE: cover property (@(posedge core_clk) disable iff (!rst_b) failsafe_entry && reg_wr);
endmodule : wscr_regs

// ===== rtl/wscr_pkg.sv
// Package for the wake source configuration register bank.
// Assumes a register access port driven by the chip's SPI frame decoder.
package wscr_pkg;
   // ==========================================================
   // Register addresses (7-bit SPI address space)
   localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
   localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
   localparam logic [6:0] ADDR_PULL = 7'h08;

   // ==========================================================
   // Field positions
   localparam int INT_T2_BIT = 7;
   localparam int INT_T1_BIT = 6;
   localparam int INT_WDH_BIT = 2;
   localparam int EXT_GLOBAL_BIT = 7;
   localparam int EXT_MEAS_BIT = 5;
   localparam int EXT_WK3_BIT = 2;
   localparam int EXT_WK2_BIT = 1;
   localparam int EXT_WK1_BIT = 0;
   localparam int WDCTL_LOW_BIT = 6;

   // ==========================================================
   // Writable masks, reset, restart and fail-safe values
   localparam logic [7:0] INT_WAKE_MASK = 8'hC4;
   localparam logic [7:0] EXT_WAKE_MASK = 8'hA7;
   localparam logic [7:0] PULL_MASK = 8'h3F;
   localparam logic [7:0] INT_WAKE_RESET = 8'h00;
   localparam logic [7:0] EXT_WAKE_RESET = 8'h07;
   localparam logic [7:0] PULL_RESET = 8'h00;
   localparam logic [7:0] EXT_RESTART_KEEP = 8'hA7;
   localparam logic [7:0] EXT_FAILSAFE_KEEP = 8'hA0;
   localparam logic [7:0] EXT_FAILSAFE_SET = 8'h07;

   // ==========================================================
   // Bus transceiver mode code meaning wake capable
   localparam logic [1:0] BUS_MODE_WAKE = 2'h1;

   typedef enum logic [1:0] {
      WSCR_PULL_NONE,
      WSCR_PULL_DOWN,
      WSCR_PULL_UP,
      WSCR_PULL_AUTO
   } wscr_pull_t;

   typedef struct packed {
      logic timer2;
      logic timer1;
      logic hv3;
      logic hv2;
      logic hv1;
      logic can;
      logic lin1;
      logic lin2;
   } wscr_wake_src_t;

   typedef struct packed {
      logic pd3;
      logic pu3;
      logic pd2;
      logic pu2;
      logic pd1;
      logic pu1;
      logic auto3;
      logic auto2;
      logic auto1;
   } wscr_pull_ctl_t;
endpackage : wscr_pkg

// ===== testbench/wscr_host.sv
// Host model: issues single-byte writes and reads on the register port.
// Assumes its tasks are called only after reset has been released.
`timescale 1ns/100ps
module wscr_host (
   input wire logic core_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
   end
   // Data is inverted once taken, so a stale byte can never pass for a new one
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      #1;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      h = reg_hit;
   endtask : rd
endmodule : wscr_host

// ===== testbench/tb_wscr_regs.sv
// Self-checking bench for the wake source configuration registers.
// Assumes the host model in wscr_host.sv drives the register port.
`timescale 1ns/100ps
module tb_wscr_regs;
   logic core_clk, rst_b, soft_reset, restart, failsafe_entry, wd_off_high_set, wd_off_high_clr;
   logic normal_mode, wake_event, status_event, reg_wr, reg_rd, reg_hit, int_request, measure_enable;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, watchdog_control;
   logic [1:0] can_mode, lin1_mode, lin2_mode, stop_watchdog_off_code;
   wscr_pkg::wscr_wake_src_t wake_sources;
   wscr_pkg::wscr_pull_ctl_t pull_ctl;
   int mismatches, total_checks, cyc;
   wscr_regs dut (.core_clk, .rst_b, .soft_reset, .restart, .failsafe_entry, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_hit, .wd_off_high_set, .wd_off_high_clr, .watchdog_control, .can_mode,
      .lin1_mode, .lin2_mode, .normal_mode, .wake_event, .status_event, .int_request, .wake_sources,
      .measure_enable, .stop_watchdog_off_code, .pull_ctl);
   wscr_host host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit);
   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rc(input logic [6:0] a, input logic [8:0] e);
      logic [7:0] d;
      logic h;
      host.rd(a, d, h);
      chk({h, d}, e);
   endtask : rc
   // One-cycle pulse on {soft_reset, restart, failsafe_entry, set, clear}
   task automatic ev(input logic [4:0] m);
      @(posedge core_clk);
      {soft_reset, restart, failsafe_entry, wd_off_high_set, wd_off_high_clr} <= m;
      @(posedge core_clk);
      {soft_reset, restart, failsafe_entry, wd_off_high_set, wd_off_high_clr} <= 5'h00;
      #1;
   endtask : ev
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rc(7'h06, 9'h100);
      rc(7'h07, 9'h107);
      rc(7'h08, 9'h100);
      rc(7'h09, 9'h000);
      chk(wake_sources, 16'h0038);
   endtask : t_reset
   task automatic t_rsvd;
      host.wr(7'h06, 8'h3B);
      rc(7'h06, 9'h100);
      host.wr(7'h06, 8'hFF);
      host.wr(7'h07, 8'hFF);
      host.wr(7'h08, 8'hFF);
      rc(7'h06, 9'h1C4);
      rc(7'h07, 9'h1A7);
      rc(7'h08, 9'h13F);
      chk(wake_sources, 16'h00E0);
      chk(stop_watchdog_off_code, 16'h0002);
   endtask : t_rsvd
   task automatic t_ext;
      for (int i = 0; i < 32; i++) begin
         host.wr(7'h07, {i[4], 1'b0, i[3], 2'b00, i[2:0]});
         chk(wake_sources[5:3], {i[2], i[1] & ~i[3], i[0] & ~i[3]});
         chk(measure_enable, i[3]);
         chk(int_request, i[4]);
      end
      @(posedge core_clk);
      wake_event <= 1'b1;
      status_event <= 1'b0;
      normal_mode <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(int_request, 16'h0001);
      chk(measure_enable, 16'h0000);
   endtask : t_ext
   task automatic t_pull;
      logic [8:0] e;
      for (int f = 0; f < 3; f++) begin
         for (int c = 0; c < 4; c++) begin
            e = '0;
            e[4 + 2 * f] = (c == 1);
            e[3 + 2 * f] = (c == 2);
            e[f] = (c == 3);
            host.wr(7'h08, 8'(c << (2 * f)));
            chk(pull_ctl, e);
         end
      end
   endtask : t_pull
   task automatic t_events;
      ev(5'h10);
      rc(7'h08, 9'h100);
      rc(7'h07, 9'h107);
      host.wr(7'h07, 8'hA6);
      ev(5'h08);
      rc(7'h07, 9'h1A6);
      host.wr(7'h07, 8'hA0);
      ev(5'h04);
      rc(7'h07, 9'h1A7);
      host.wr(7'h07, 8'h00);
      fork
         host.wr(7'h07, 8'hA0);
         ev(5'h04);
      join
      rc(7'h07, 9'h107);
   endtask : t_events
   task automatic t_wd;
      ev(5'h02);
      rc(7'h06, 9'h104);
      ev(5'h01);
      chk(stop_watchdog_off_code, 16'h0000);
      ev(5'h03);
      @(posedge core_clk);
      watchdog_control <= 8'h40;
      @(posedge core_clk);
      #1;
      chk(stop_watchdog_off_code, 16'h0003);
   endtask : t_wd
   task automatic t_bus;
      for (int m = 0; m < 4; m++) begin
         @(posedge core_clk);
         can_mode <= m[1:0];
         lin1_mode <= m[1:0];
         lin2_mode <= 2'(m + 1);
         @(posedge core_clk);
         #1;
         chk(wake_sources[2:0], {m == 1, m == 1, m == 0});
      end
   endtask : t_bus
   // ==========================================================
   // Clock, reset, sequence and watchdog on the run length
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      {rst_b, soft_reset, restart, failsafe_entry, wd_off_high_set, wd_off_high_clr} = 6'h00;
      {normal_mode, wake_event, status_event} = 3'b101;
      {watchdog_control, can_mode, lin1_mode, lin2_mode} = 14'h0000;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset();
      t_rsvd();
      t_ext();
      t_pull();
      t_events();
      t_wd();
      t_bus();
      report_and_stop();
   end
endmodule : tb_wscr_regs
